//--- logic/queue_engine_pkg.sv
// package: constants, states and carriers of the queue doorbell engine
package queue_engine_pkg;
	// ==========================================
	// widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int PTR_W = 8;
	localparam int TAG_W = 16;
	localparam int THR_W = 8;
	localparam int PRIO_W = 2;
	localparam int STATUS_W = 15;
	localparam int QIDF_W = 16;

	// ==========================================
	// register map
	localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
	localparam logic [ADDR_W-1:0] PRIO_OFF = 12'h004;
	localparam logic [ADDR_W-1:0] STAT_OFF = 12'h008;
	localparam logic [ADDR_W-1:0] DB_BASE = 12'h100;
	localparam int DB_STRIDE_LSB = 3;
	localparam int DB_CQ_BIT = 2;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_THR_LSB = 8;
	localparam int STAT_SLOT_LSB = 0;
	localparam int STAT_IRQ_LSB = 16;
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [THR_W-1:0] CTRL_THR_RST = 8'h00;

	// ==========================================
	// command dword 0 layout and chaining codes
	localparam int OPC_LSB = 0;
	localparam int CHAIN_LSB = 8;
	localparam int TAG_LSB = 16;
	localparam logic [1:0] CHAIN_NONE = 2'h0;
	localparam logic [1:0] CHAIN_FIRST = 2'h1;
	localparam logic [1:0] CHAIN_SECOND = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_FETCH = 3'h2,
		ST_POST = 3'h4
	} phase_e;

	typedef struct packed {
		logic [7:0] command_opcode;
		logic [1:0] command_chaining_code;
		logic [TAG_W-1:0] command_tag;
	} cmd_s;

	// completion dword 2: queue ident high, fetched position low
	typedef struct packed {
		logic [QIDF_W-1:0] submit_queue_ident;
		logic [QIDF_W-1:0] sq_head;
	} cpl_dw2_s;

	// completion dword 3: status, phase, tag
	typedef struct packed {
		logic [STATUS_W-1:0] completion_status_field;
		logic phase;
		logic [TAG_W-1:0] command_tag;
	} cpl_dw3_s;
endpackage

//--- logic/ring_pointers.sv
// one queue's pair of wrapping pointers: one end loaded by doorbell, one stepped by hardware
`timescale 1ns/1ps
module ring_pointers #(
	parameter int DEPTH = 16,
	parameter int PTR_W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic load,
	input wire logic [PTR_W-1:0] load_val,
	input wire logic step,
	output logic [PTR_W-1:0] load_ptr,
	output logic [PTR_W-1:0] step_ptr,
	output logic [PTR_W-1:0] count,
	output logic full,
	output logic phase
);
	localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] SIZE = PTR_W'(DEPTH);

	typedef struct packed {
		logic [PTR_W-1:0] load_ptr;
		logic [PTR_W-1:0] step_ptr;
		logic phase;
	} st_s;

	st_s s_q;
	st_s s_d;
	logic [PTR_W-1:0] step_next;

	assign step_next = (s_q.step_ptr == LAST) ? '0 : s_q.step_ptr + 1'b1; // RULE_23

	always_comb begin
		s_d = s_q;
		// a doorbell beyond the ring is dropped rather than corrupting the count
		if (load && load_val <= LAST) begin
			s_d.load_ptr = load_val;
		end
		if (step) begin
			s_d.step_ptr = step_next;
			if (s_q.step_ptr == LAST) begin
				s_d.phase = ~s_q.phase;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{load_ptr: '0, step_ptr: '0, phase: 1'b1};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign load_ptr = s_q.load_ptr;
	assign step_ptr = s_q.step_ptr;
	assign phase = s_q.phase;
	// entries between stepped and loaded end, modulo the ring
	assign count = (s_q.load_ptr >= s_q.step_ptr) ? s_q.load_ptr - s_q.step_ptr
		: SIZE - s_q.step_ptr + s_q.load_ptr; // RULE_01
	assign full = (step_next == s_q.load_ptr); // RULE_23
endmodule // ring_pointers

//--- logic/prio_rr_arbiter.sv
// picker: highest priority class first, round robin inside a class
`timescale 1ns/1ps
module prio_rr_arbiter #(
	parameter int N = 4,
	parameter int PRIO_W = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [N-1:0] req,
	input wire logic [N-1:0][PRIO_W-1:0] prio,
	input wire logic advance,
	output logic any,
	output logic [$clog2(N)-1:0] idx
);
	localparam int IW = $clog2(N);

	typedef struct packed {
		logic [IW-1:0] last;
	} st_s;

	st_s s_q;
	st_s s_d;
	int cand;

	always_comb begin
		any = 1'b0;
		idx = '0;
		cand = 0;
		for (int p = (1 << PRIO_W) - 1; p >= 0; p--) begin
			for (int k = 1; k <= N; k++) begin
				cand = (int'(s_q.last) + k) % N;
				if (!any && req[cand] && int'(prio[cand]) == p) begin
					any = 1'b1;
					idx = IW'(cand);
				end
			end
		end
		s_d = s_q;
		if (advance && any) begin
			s_d.last = idx;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
endmodule // prio_rr_arbiter

//--- logic/queue_doorbell_engine.sv
// top of the queue doorbell engine: register slave, fetch, dispatch and completion posting
// Notes on behaviour
// RULE_01: new commands are new tail minus old
// RULE_02: host announces work by writing tail doorbell
// RULE_03: tail doorbell triggers fetch and holding of entries
// RULE_04: any execution order except fused pairs
// RULE_05: media commit order may differ from arrival
// RULE_06: queue priority per command, fair priority arbitration
// RULE_07: every finished command posts one completion
// RULE_08: completion reports latest fetched submission position
// RULE_09: completion carries queue ident and command tag
// RULE_10: completions may post in any order
// RULE_11: interrupt vector tells which completion queues
// RULE_12: interrupt after posting, coalescing may suppress
// RULE_13: head doorbell releases entries, clears interrupt
// RULE_14: host may consume many before one doorbell
// RULE_15: host checks queue not full before placing
// RULE_16: host sets unique tag, opcode, chaining, namespace
// RULE_17: host fills pointers only for data transfers
// RULE_18: host creates queues before submitting
// RULE_19: host reuses slot only after fetch reported
// RULE_20: chaining code 01 first, 10 second
// RULE_21: fused pair announced by one doorbell
// RULE_22: queue ident in dword 2, tag/status dword 3
// RULE_23: wrapping pointers, never post to full queue
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module queue_doorbell_engine #(
	parameter int NUM_Q = 4,
	parameter int DEPTH = 16,
	parameter int SLOTS = 8
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [queue_engine_pkg::ADDR_W-1:0] PADDR,
	input wire logic [queue_engine_pkg::DATA_W-1:0] PWDATA,
	output logic [queue_engine_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic FETCH_REQ,
	output logic [$clog2(NUM_Q)-1:0] FETCH_QID,
	output logic [queue_engine_pkg::PTR_W-1:0] FETCH_SLOT,
	input wire logic FETCH_ACK,
	input wire logic [queue_engine_pkg::DATA_W-1:0] FETCH_DW0,
	output logic EXEC_VALID,
	output queue_engine_pkg::cmd_s EXEC_CMD,
	output logic [$clog2(NUM_Q)-1:0] EXEC_QID,
	input wire logic EXEC_READY,
	input wire logic DONE_VALID,
	input wire logic [$clog2(NUM_Q)-1:0] DONE_QID,
	input wire logic [queue_engine_pkg::TAG_W-1:0] DONE_TAG,
	input wire logic [queue_engine_pkg::STATUS_W-1:0] DONE_STATUS,
	output logic DONE_READY,
	output logic POST_VALID,
	output logic [$clog2(NUM_Q)-1:0] POST_QID,
	output logic [queue_engine_pkg::PTR_W-1:0] POST_SLOT,
	output queue_engine_pkg::cpl_dw2_s POST_DW2,
	output queue_engine_pkg::cpl_dw3_s POST_DW3,
	input wire logic POST_ACK,
	output logic [NUM_Q-1:0] CQ_IRQ
);
	localparam int QID_W = $clog2(NUM_Q);
	localparam int SLOT_W = $clog2(SLOTS);
	localparam int PW = queue_engine_pkg::PTR_W;
	localparam int THR_W = queue_engine_pkg::THR_W;
	localparam int PRIO_W = queue_engine_pkg::PRIO_W;

	typedef struct packed {
		queue_engine_pkg::phase_e fsm;
		logic en;
		logic [THR_W-1:0] thr;
		logic [NUM_Q-1:0][PRIO_W-1:0] prio;
		logic pready;
		logic pslverr;
		logic [queue_engine_pkg::DATA_W-1:0] prdata;
		logic [SLOTS-1:0] slot_v;
		queue_engine_pkg::cmd_s [SLOTS-1:0] slot_cmd;
		logic [SLOTS-1:0][QID_W-1:0] slot_qid;
		logic [SLOT_W-1:0] fetch_slot;
		logic fetch_req;
		logic [QID_W-1:0] fetch_qid;
		logic [PW-1:0] fetch_ptr;
		logic exec_v;
		queue_engine_pkg::cmd_s exec_cmd;
		logic [QID_W-1:0] exec_qid;
		logic done_ready;
		logic cpl_pend;
		logic [QID_W-1:0] pend_qid;
		logic [queue_engine_pkg::TAG_W-1:0] pend_tag;
		logic [queue_engine_pkg::STATUS_W-1:0] pend_status;
		logic post_v;
		logic [PW-1:0] post_slot;
		queue_engine_pkg::cpl_dw2_s dw2;
		queue_engine_pkg::cpl_dw3_s dw3;
		logic [NUM_Q-1:0][THR_W-1:0] coal;
		logic [NUM_Q-1:0] irq;
	} st_s;

	st_s s_q;
	st_s s_d;

	// ==========================================
	// queue pointers
	logic [NUM_Q-1:0] sq_load;
	logic [NUM_Q-1:0] sq_step;
	logic [NUM_Q-1:0] cq_load;
	logic [NUM_Q-1:0] cq_step;
	logic [NUM_Q-1:0][PW-1:0] sq_tail;
	logic [NUM_Q-1:0][PW-1:0] sq_head;
	logic [NUM_Q-1:0][PW-1:0] sq_count;
	logic [NUM_Q-1:0][PW-1:0] cq_head;
	logic [NUM_Q-1:0][PW-1:0] cq_tail;
	logic [NUM_Q-1:0] cq_full;
	logic [NUM_Q-1:0] cq_phase;

	for (genvar q = 0; q < NUM_Q; q++) begin : g_queue
		ring_pointers #(.DEPTH(DEPTH), .PTR_W(PW)) u_sq (
			.clk(CLOCK), .resetn(RESETN), .ce(CE),
			.load(sq_load[q]), .load_val(PWDATA[PW-1:0]), .step(sq_step[q]),
			.load_ptr(sq_tail[q]), .step_ptr(sq_head[q]), .count(sq_count[q]),
			.full(), .phase()
		);
		ring_pointers #(.DEPTH(DEPTH), .PTR_W(PW)) u_cq (
			.clk(CLOCK), .resetn(RESETN), .ce(CE),
			.load(cq_load[q]), .load_val(PWDATA[PW-1:0]), .step(cq_step[q]),
			.load_ptr(cq_head[q]), .step_ptr(cq_tail[q]), .count(),
			.full(cq_full[q]), .phase(cq_phase[q])
		);
	end

	// ==========================================
	// eligibility and arbitration
	logic [NUM_Q-1:0] first_held;
	logic [SLOTS-1:0] elig;
	logic [SLOTS-1:0][PRIO_W-1:0] slot_prio;
	logic [NUM_Q-1:0] fetch_want;
	logic free_any;
	logic [SLOT_W-1:0] free_idx;
	logic disp_any;
	logic [SLOT_W-1:0] disp_idx;
	logic fetch_any;
	logic [QID_W-1:0] fetch_idx;
	logic exec_load;
	logic fetch_go;
	logic [PRIO_W-1:0] max_prio;

	always_comb begin
		first_held = '0;
		free_any = 1'b0;
		free_idx = '0;
		max_prio = '0;
		for (int i = 0; i < SLOTS; i++) begin
			if (s_q.slot_v[i] && s_q.slot_cmd[i].command_chaining_code == queue_engine_pkg::CHAIN_FIRST) begin
				first_held[s_q.slot_qid[i]] = 1'b1; // RULE_20
			end
		end
		for (int i = SLOTS - 1; i >= 0; i--) begin
			// a second half waits while its first half is still held
			elig[i] = s_q.slot_v[i] && !(first_held[s_q.slot_qid[i]]
				&& s_q.slot_cmd[i].command_chaining_code == queue_engine_pkg::CHAIN_SECOND); // RULE_04
			slot_prio[i] = s_q.prio[s_q.slot_qid[i]]; // RULE_06
			if (elig[i] && slot_prio[i] > max_prio) begin
				max_prio = slot_prio[i];
			end
			if (!s_q.slot_v[i]) begin
				free_any = 1'b1;
				free_idx = SLOT_W'(i);
			end
		end
		for (int q = 0; q < NUM_Q; q++) begin
			fetch_want[q] = (sq_count[q] != '0); // RULE_03
		end
	end

	// execution order is free apart from fused pairs; media commit order is downstream
	prio_rr_arbiter #(.N(SLOTS), .PRIO_W(PRIO_W)) u_disp_arb (
		.clk(CLOCK), .resetn(RESETN), .ce(CE), .req(elig), .prio(slot_prio),
		.advance(exec_load), .any(disp_any), .idx(disp_idx)
	); // RULE_05 RULE_06

	prio_rr_arbiter #(.N(NUM_Q), .PRIO_W(PRIO_W)) u_fetch_arb (
		.clk(CLOCK), .resetn(RESETN), .ce(CE), .req(fetch_want), .prio(s_q.prio),
		.advance(fetch_go), .any(fetch_any), .idx(fetch_idx)
	); // RULE_06

	// ==========================================
	// register decode
	logic [queue_engine_pkg::ADDR_W-1:0] db_off;
	logic db_hit;
	logic [QID_W-1:0] db_q;
	logic map_hit;
	logic wr_fire;
	logic [queue_engine_pkg::DATA_W-1:0] rd;

	assign db_off = PADDR - queue_engine_pkg::DB_BASE;
	assign db_q = db_off[queue_engine_pkg::DB_STRIDE_LSB +: QID_W];
	assign db_hit = PADDR >= queue_engine_pkg::DB_BASE && PADDR[1:0] == 2'h0
		&& (db_off >> queue_engine_pkg::DB_STRIDE_LSB) < queue_engine_pkg::ADDR_W'(NUM_Q);
	assign map_hit = db_hit || PADDR == queue_engine_pkg::CTRL_OFF || PADDR == queue_engine_pkg::PRIO_OFF
		|| PADDR == queue_engine_pkg::STAT_OFF;
	assign wr_fire = PSEL && PENABLE && PWRITE && s_q.pready && !s_q.pslverr;

	// ==========================================
	// next state
	always_comb begin
		s_d = s_q;
		sq_load = '0;
		cq_load = '0;
		sq_step = '0;
		cq_step = '0;
		exec_load = 1'b0;
		fetch_go = 1'b0;
		rd = '0;
		if (PADDR == queue_engine_pkg::CTRL_OFF) begin
			rd[queue_engine_pkg::CTRL_EN_BIT] = s_q.en;
			rd[queue_engine_pkg::CTRL_THR_LSB +: THR_W] = s_q.thr;
		end else if (PADDR == queue_engine_pkg::PRIO_OFF) begin
			rd[NUM_Q*PRIO_W-1:0] = s_q.prio;
		end else if (PADDR == queue_engine_pkg::STAT_OFF) begin
			rd[queue_engine_pkg::STAT_SLOT_LSB +: SLOTS] = s_q.slot_v;
			rd[queue_engine_pkg::STAT_IRQ_LSB +: NUM_Q] = s_q.irq;
		end else if (db_hit) begin
			rd[PW-1:0] = db_off[queue_engine_pkg::DB_CQ_BIT] ? cq_head[db_q] : sq_tail[db_q];
		end
		// answer one cycle into the access phase, so every access takes three
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (PSEL && PENABLE && !s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.pslverr = !map_hit;
			s_d.prdata = rd;
		end
		if (wr_fire) begin
			if (PADDR == queue_engine_pkg::CTRL_OFF) begin
				s_d.en = PWDATA[queue_engine_pkg::CTRL_EN_BIT];
				s_d.thr = PWDATA[queue_engine_pkg::CTRL_THR_LSB +: THR_W];
			end
			if (PADDR == queue_engine_pkg::PRIO_OFF) begin
				s_d.prio = PWDATA[NUM_Q*PRIO_W-1:0];
			end
			sq_load[db_q] = db_hit && !db_off[queue_engine_pkg::DB_CQ_BIT]; // RULE_01 RULE_02
			cq_load[db_q] = db_hit && db_off[queue_engine_pkg::DB_CQ_BIT]; // RULE_13 RULE_14
		end
		for (int q = 0; q < NUM_Q; q++) begin
			if (cq_load[q]) begin
				s_d.irq[q] = 1'b0; // RULE_13
				s_d.coal[q] = '0;
			end
		end
		if (DONE_VALID && s_q.done_ready) begin
			s_d.done_ready = 1'b0; // RULE_07
			s_d.cpl_pend = 1'b1;
			s_d.pend_qid = DONE_QID;
			s_d.pend_tag = DONE_TAG;
			s_d.pend_status = DONE_STATUS;
		end
		if (s_q.exec_v && EXEC_READY) begin
			s_d.exec_v = 1'b0;
		end
		if ((!s_q.exec_v || EXEC_READY) && s_q.en && disp_any) begin
			exec_load = 1'b1; // RULE_04
			s_d.exec_v = 1'b1;
			s_d.exec_cmd = s_q.slot_cmd[disp_idx];
			s_d.exec_qid = s_q.slot_qid[disp_idx];
			s_d.slot_v[disp_idx] = 1'b0;
		end
		unique case (s_q.fsm)
			queue_engine_pkg::ST_IDLE: begin
				// posting first: it frees execution capacity sooner than fetching more; any order is fine
				if (s_q.cpl_pend && !cq_full[s_q.pend_qid]) begin // RULE_10 RULE_23
					s_d.fsm = queue_engine_pkg::ST_POST;
					s_d.post_v = 1'b1;
					s_d.post_slot = cq_tail[s_q.pend_qid];
					s_d.dw2.submit_queue_ident = queue_engine_pkg::QIDF_W'(s_q.pend_qid); // RULE_09 RULE_22
					s_d.dw2.sq_head = queue_engine_pkg::QIDF_W'(sq_head[s_q.pend_qid]); // RULE_08
					s_d.dw3.completion_status_field = s_q.pend_status; // RULE_22
					s_d.dw3.phase = cq_phase[s_q.pend_qid];
					s_d.dw3.command_tag = s_q.pend_tag; // RULE_09
				end else if (s_q.en && fetch_any && free_any) begin
					fetch_go = 1'b1; // RULE_03
					s_d.fsm = queue_engine_pkg::ST_FETCH;
					s_d.fetch_req = 1'b1;
					s_d.fetch_qid = fetch_idx;
					s_d.fetch_ptr = sq_head[fetch_idx];
					s_d.fetch_slot = free_idx;
				end
			end
			queue_engine_pkg::ST_FETCH: begin
				if (FETCH_ACK) begin
					s_d.fsm = queue_engine_pkg::ST_IDLE;
					s_d.fetch_req = 1'b0;
					sq_step[s_q.fetch_qid] = 1'b1; // RULE_03 RULE_19
					s_d.slot_v[s_q.fetch_slot] = 1'b1;
					s_d.slot_qid[s_q.fetch_slot] = s_q.fetch_qid;
					s_d.slot_cmd[s_q.fetch_slot].command_opcode = FETCH_DW0[queue_engine_pkg::OPC_LSB +: 8];
					s_d.slot_cmd[s_q.fetch_slot].command_chaining_code = FETCH_DW0[queue_engine_pkg::CHAIN_LSB +: 2];
					s_d.slot_cmd[s_q.fetch_slot].command_tag =
						FETCH_DW0[queue_engine_pkg::TAG_LSB +: queue_engine_pkg::TAG_W];
				end
			end
			queue_engine_pkg::ST_POST: begin
				if (POST_ACK) begin
					s_d.fsm = queue_engine_pkg::ST_IDLE;
					s_d.post_v = 1'b0;
					s_d.cpl_pend = 1'b0;
					s_d.done_ready = 1'b1;
					cq_step[s_q.pend_qid] = 1'b1; // RULE_07 RULE_23
					// coalescing: threshold 0 or 1 signals every completion; post set beats doorbell clear
					if (s_q.coal[s_q.pend_qid] + 1'b1 >= s_q.thr) begin
						s_d.irq[s_q.pend_qid] = 1'b1; // RULE_11 RULE_12
						s_d.coal[s_q.pend_qid] = '0;
					end else begin
						s_d.coal[s_q.pend_qid] = s_q.coal[s_q.pend_qid] + 1'b1; // RULE_12
					end
				end
			end
			default: begin
				s_d.fsm = queue_engine_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			s_q <= '0;
			s_q.fsm <= queue_engine_pkg::ST_IDLE;
			s_q.en <= queue_engine_pkg::CTRL_EN_RST;
			s_q.thr <= queue_engine_pkg::CTRL_THR_RST;
			s_q.done_ready <= 1'b1;
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign FETCH_REQ = s_q.fetch_req;
	assign FETCH_QID = s_q.fetch_qid;
	assign FETCH_SLOT = s_q.fetch_ptr;
	assign EXEC_VALID = s_q.exec_v;
	assign EXEC_CMD = s_q.exec_cmd;
	assign EXEC_QID = s_q.exec_qid;
	assign DONE_READY = s_q.done_ready;
	assign POST_VALID = s_q.post_v;
	assign POST_QID = s_q.pend_qid;
	assign POST_SLOT = s_q.post_slot;
	assign POST_DW2 = s_q.dw2;
	assign POST_DW3 = s_q.dw3;
	assign CQ_IRQ = s_q.irq;

	// ==========================================
	// assertions
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN || !CE);

	a_tail_doorbell_load: assert property (wr_fire && sq_load[0] && PWDATA[PW-1:0] < PW'(DEPTH) // RULE_01
		|=> sq_tail[0] == $past(PWDATA[PW-1:0])) else $error("tail doorbell not taken");
	a_fetch_at_head: assert property ($rose(FETCH_REQ) |-> FETCH_SLOT == sq_head[FETCH_QID] // RULE_03
		&& sq_count[FETCH_QID] != '0) else $error("fetch not at queue head");
	a_fetch_held: assert property (FETCH_REQ && FETCH_ACK |=> !FETCH_REQ && s_q.slot_v[$past(s_q.fetch_slot)]) // RULE_03
		else $error("fetched command not held");
	a_fused_order: assert property (exec_load && s_d.exec_cmd.command_chaining_code == queue_engine_pkg::CHAIN_SECOND // RULE_04
		|-> !first_held[s_d.exec_qid]) else $error("fused second overtook first");
	a_prio_grant: assert property (exec_load |-> slot_prio[disp_idx] == max_prio) // RULE_06
		else $error("lower priority command dispatched");
	a_done_captured: assert property (DONE_VALID && DONE_READY |=> !DONE_READY ##0 s_q.pend_tag == $past(DONE_TAG)) // RULE_07
		else $error("completion not captured");
	a_post_tag: assert property ($rose(POST_VALID) |-> POST_DW3.command_tag == $past(s_q.pend_tag) // RULE_09
		&& POST_DW2.submit_queue_ident == queue_engine_pkg::QIDF_W'(POST_QID)) else $error("completion ident wrong");
	a_post_sq_head: assert property ($rose(POST_VALID) |-> POST_DW2.sq_head == queue_engine_pkg::QIDF_W'(sq_head[POST_QID])) // RULE_08
		else $error("completion head position wrong");
	a_no_full_post: assert property ($rose(POST_VALID) |-> $past(!cq_full[s_q.pend_qid])) // RULE_23
		else $error("posted to full completion queue");
	a_irq_raise: assert property (POST_VALID && POST_ACK && s_q.thr <= 8'h01 |=> CQ_IRQ[$past(POST_QID)]) // RULE_12
		else $error("interrupt not raised after post");
	a_irq_clear: assert property (wr_fire && cq_load[0] && !(POST_VALID && POST_ACK) |=> !CQ_IRQ[0]) // RULE_13
		else $error("head doorbell did not clear interrupt");
	a_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("bus access not answered");

	c_fetch: cover property (FETCH_REQ && FETCH_ACK);
	c_post: cover property (POST_VALID && POST_ACK);
	c_fused: cover property (exec_load && s_d.exec_cmd.command_chaining_code == queue_engine_pkg::CHAIN_SECOND);
	c_irq: cover property ($fell(CQ_IRQ[0]));
endmodule // queue_doorbell_engine

//--- verification/host_mem_model.sv
// host memory stand-in: answers command fetches and completion writes
`timescale 1ns/1ps
module host_mem_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic fetch_req,
	input wire logic [1:0] fetch_qid,
	input wire logic [7:0] fetch_slot,
	output logic fetch_ack = 1'b0,
	output logic [31:0] fetch_dw0 = 32'h0,
	input wire logic post_valid,
	output logic post_ack = 1'b0
);
	// ==========================================
	// queue memory, filled by the host driver
	// only dword 0 kept: no command here moves data, so no pointer dwords
	logic [31:0] mem [4][4];
	int fcnt = 0;
	logic [3:0] w = 4'h0;
	always @(posedge clk) begin
		w <= w + 4'h1;
		fetch_ack <= fetch_req && !fetch_ack && (!slow || w[1:0] == 2'h3);
		post_ack <= post_valid && !post_ack && (!slow || w[0]);
		if (fetch_req && !fetch_ack && (!slow || w[1:0] == 2'h3)) begin
			fetch_dw0 <= mem[fetch_qid][fetch_slot[1:0]];
			fcnt <= fcnt + 1;
		end else begin
			// released data lines keep moving so a stale sample cannot match
			fetch_dw0 <= ~fetch_dw0;
		end
	end
endmodule // host_mem_model

//--- verification/queue_doorbell_engine_test.sv
// self-checking bench of the queue doorbell engine
`timescale 1ns/1ps
module queue_doorbell_engine_test;
	// ==========================================
	// signals
	localparam int DEPTH = 4;
	typedef struct packed {
		logic [1:0] q;
		logic [15:0] tag;
		logic [14:0] st;
		logic [7:0] head;
		logic [7:0] op;
	} note_s;
	logic CLOCK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic EXEC_READY = 1'b0, DONE_VALID = 1'b0, SLOW = 1'b0, go = 1'b0, fz = 1'b0, pri = 1'b0, CE = 1'b1;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, FETCH_DW0, r;
	logic PREADY, PSLVERR, FETCH_REQ, FETCH_ACK, EXEC_VALID, DONE_READY, POST_VALID, POST_ACK, e;
	logic [1:0] FETCH_QID, EXEC_QID, POST_QID, DONE_QID = 2'h0;
	logic [7:0] FETCH_SLOT, POST_SLOT, sqt [4], cqt [4];
	logic [15:0] DONE_TAG = 16'h0, tg = 16'h0100, rnd = 16'h0028, rs = 16'h0028;
	logic [14:0] DONE_STATUS = 15'h0;
	logic [3:0] CQ_IRQ;
	queue_engine_pkg::cmd_s EXEC_CMD;
	queue_engine_pkg::cpl_dw2_s POST_DW2;
	queue_engine_pkg::cpl_dw3_s POST_DW3;
	note_s exp_q [$];
	note_s n;
	int ia [$], ib [$];
	int err_total = 0, tests_run = 0, cyc = 0;

	always #20 CLOCK = ~CLOCK;

	queue_doorbell_engine #(.NUM_Q(4), .DEPTH(DEPTH), .SLOTS(8)) queue_doorbell_engine_inst (
		.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.FETCH_REQ(FETCH_REQ), .FETCH_QID(FETCH_QID), .FETCH_SLOT(FETCH_SLOT), .FETCH_ACK(FETCH_ACK),
		.FETCH_DW0(FETCH_DW0), .EXEC_VALID(EXEC_VALID), .EXEC_CMD(EXEC_CMD), .EXEC_QID(EXEC_QID),
		.EXEC_READY(EXEC_READY), .DONE_VALID(DONE_VALID), .DONE_QID(DONE_QID), .DONE_TAG(DONE_TAG),
		.DONE_STATUS(DONE_STATUS), .DONE_READY(DONE_READY), .POST_VALID(POST_VALID), .POST_QID(POST_QID),
		.POST_SLOT(POST_SLOT), .POST_DW2(POST_DW2), .POST_DW3(POST_DW3), .POST_ACK(POST_ACK), .CQ_IRQ(CQ_IRQ));

	host_mem_model host_mem_model_inst (.clk(CLOCK), .slow(SLOW), .fetch_req(FETCH_REQ), .fetch_qid(FETCH_QID),
		.fetch_slot(FETCH_SLOT), .fetch_ack(FETCH_ACK), .fetch_dw0(FETCH_DW0), .post_valid(POST_VALID),
		.post_ack(POST_ACK));

	// ==========================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic close_out();
		$display("mismatches %0d of %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// waits as long as the slave takes; only the timeout ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// places cnt commands and announces them all with one tail write
	task automatic submit(input logic [1:0] q, input int cnt, input logic fused);
		logic [1:0] ch;
		go <= 1'b0;
		n.q = q;
		n.st = 15'h0;
		n.head = (sqt[q] + cnt) % DEPTH;
		for (int i = 0; i < cnt; i++) begin
			ch = fused ? 2'(i + 1) : queue_engine_pkg::CHAIN_NONE;
			rnd = lfsr(rnd);
			n.op = rnd[7:0];
			host_mem_model_inst.mem[q][sqt[q][1:0]] = {tg, 6'h00, ch, rnd[7:0]};
			n.tag = tg;
			exp_q.push_back(n);
			tg++;
			sqt[q] = (sqt[q] + 1) % DEPTH;
		end
		apb(1'b1, queue_engine_pkg::DB_BASE + 12'(q) * 12'h008, 32'(sqt[q]));
	endtask

	task automatic drain();
		repeat (600) if (exp_q.size() != 0) @(posedge CLOCK);
		// let the last post's flag updates settle before anything is read
		@(posedge CLOCK);
		chk("notes left", 0, exp_q.size());
	endtask

	// execution waits until all is fetched, so each completion reports the final head
	task automatic fetch_wait(input int f);
		repeat (200) if (host_mem_model_inst.fcnt < f) @(posedge CLOCK);
		chk("fetched", f, host_mem_model_inst.fcnt);
		go <= 1'b1;
	endtask

	// ==========================================
	// execution side and completion watcher
	always @(posedge CLOCK) begin
		if (DONE_READY && DONE_VALID) DONE_VALID <= 1'b0;
		EXEC_READY <= go && !DONE_VALID && !EXEC_READY;
		if (EXEC_VALID && EXEC_READY) begin
			rs = lfsr(rs);
			ib = exp_q.find_first_index(x) with (x.tag === EXEC_CMD.command_tag);
			chk("exec tag", 1, ib.size());
			if (ib.size() != 0) begin
				exp_q[ib[0]].st = rs[14:0];
				chk("exec qid", exp_q[ib[0]].q, EXEC_QID);
				chk("exec opcode", exp_q[ib[0]].op, EXEC_CMD.command_opcode);
			end
			if (!pri) chk("first pick", 2, EXEC_QID);
			pri = 1'b1;
			if (EXEC_CMD.command_chaining_code === queue_engine_pkg::CHAIN_SECOND) chk("fused order", 1, fz);
			fz = EXEC_CMD.command_chaining_code === queue_engine_pkg::CHAIN_FIRST;
			DONE_VALID <= 1'b1;
			DONE_QID <= EXEC_QID;
			DONE_TAG <= EXEC_CMD.command_tag;
			DONE_STATUS <= rs[14:0];
		end
	end

	always @(posedge CLOCK) begin
		if (POST_VALID && POST_ACK) begin
			ia = exp_q.find_first_index(x) with (x.tag === POST_DW3.command_tag);
			chk("post tag", 1, ia.size());
			if (ia.size() != 0) begin
				n = exp_q[ia[0]];
				chk("post qid", n.q, POST_QID);
				chk("sq ident", n.q, POST_DW2.submit_queue_ident);
				chk("sq head", n.head, POST_DW2.sq_head);
				chk("status", n.st, POST_DW3.completion_status_field);
				chk("cq slot", cqt[n.q], POST_SLOT);
				chk("cq phase", 1, POST_DW3.phase);
				cqt[n.q] = (cqt[n.q] + 1) % DEPTH;
				exp_q.delete(ia[0]);
			end
		end
	end

	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		for (int i = 0; i < 4; i++) begin
			sqt[i] = 8'h00;
			cqt[i] = 8'h00;
		end
		repeat (3) @(posedge CLOCK);
		RESETN <= 1'b1;
		chk("done ready", 1, DONE_READY);
		apb(1'b0, queue_engine_pkg::CTRL_OFF, 32'h0);
		chk("ctrl reset", 0, r);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped err", 1, e);
		apb(1'b1, queue_engine_pkg::PRIO_OFF, 32'h30);
		submit(2'h0, 2, 1'b0);
		submit(2'h2, 2, 1'b0);
		// enabling only now lets the highest priority queue be fetched first
		apb(1'b1, queue_engine_pkg::CTRL_OFF, 32'h1);
		fetch_wait(4);
		drain();
		chk("irq set", 4'h5, CQ_IRQ);
		apb(1'b1, 12'h104, 32'h2);
		apb(1'b1, 12'h114, 32'h2);
		@(posedge CLOCK);
		chk("irq clear", 0, CQ_IRQ);
		SLOW <= 1'b1;
		submit(2'h1, 2, 1'b1);
		// frozen engine must not start the fetch that the doorbell asked for
		CE <= 1'b0;
		repeat (8) @(posedge CLOCK);
		chk("ce freeze", 4, host_mem_model_inst.fcnt);
		CE <= 1'b1;
		fetch_wait(6);
		drain();
		submit(2'h3, 3, 1'b0);
		fetch_wait(9);
		drain();
		submit(2'h3, 1, 1'b0);
		fetch_wait(10);
		repeat (60) @(posedge CLOCK);
		chk("held post", 1, exp_q.size());
		apb(1'b1, 12'h11C, 32'h3);
		drain();
		close_out();
	end
endmodule // queue_doorbell_engine_test
